// ---- hdl/itlp_bus_if.sv ----
// open-collector bus lines joining the instrument and the controller
interface itlp_bus_if;
    logic [7:0] d_dio_o;
    logic [7:0] d_dio_oe;
    logic [7:0] c_dio_o;
    logic [7:0] c_dio_oe;
    logic d_dav_o, d_dav_oe, c_dav_o, c_dav_oe;
    logic d_nrfd_o, d_nrfd_oe, c_nrfd_o, c_nrfd_oe;
    logic d_ndac_o, d_ndac_oe, c_ndac_o, c_ndac_oe;
    logic d_eoi_o, d_eoi_oe, c_eoi_o, c_eoi_oe;
    logic d_srq_o, d_srq_oe;
    logic c_atn_o, c_atn_oe, c_ifc_o, c_ifc_oe, c_ren_o, c_ren_oe;
    logic [7:0] dio_l;
    logic dav_l, nrfd_l, ndac_l, eoi_l, srq_l, atn_l, ifc_l, ren_l;
    // wired-AND with pull-up: a line is low when any enabled driver pulls
    assign dio_l = ~(d_dio_oe & ~d_dio_o) & ~(c_dio_oe & ~c_dio_o);
    assign dav_l = ~(d_dav_oe & ~d_dav_o) & ~(c_dav_oe & ~c_dav_o);
    assign nrfd_l = ~(d_nrfd_oe & ~d_nrfd_o) & ~(c_nrfd_oe & ~c_nrfd_o);
    assign ndac_l = ~(d_ndac_oe & ~d_ndac_o) & ~(c_ndac_oe & ~c_ndac_o);
    assign eoi_l = ~(d_eoi_oe & ~d_eoi_o) & ~(c_eoi_oe & ~c_eoi_o);
    assign srq_l = ~(d_srq_oe & ~d_srq_o);
    assign atn_l = ~(c_atn_oe & ~c_atn_o);
    assign ifc_l = ~(c_ifc_oe & ~c_ifc_o);
    assign ren_l = ~(c_ren_oe & ~c_ren_o);
    modport dev (
        input dio_l, dav_l, nrfd_l, ndac_l, eoi_l, atn_l, ifc_l, ren_l,
        output d_dio_o, d_dio_oe, d_dav_o, d_dav_oe, d_nrfd_o, d_nrfd_oe,
        output d_ndac_o, d_ndac_oe, d_eoi_o, d_eoi_oe, d_srq_o, d_srq_oe
    );
    modport ctl (
        input dio_l, dav_l, nrfd_l, ndac_l, eoi_l, srq_l,
        output c_dio_o, c_dio_oe, c_dav_o, c_dav_oe, c_nrfd_o, c_nrfd_oe,
        output c_ndac_o, c_ndac_oe, c_eoi_o, c_eoi_oe,
        output c_atn_o, c_atn_oe, c_ifc_o, c_ifc_oe, c_ren_o, c_ren_oe
    );
endinterface

// ---- hdl/itlp_ctl.sv ----
// controller end: sends commands and data, receives bytes, drives management
module itlp_ctl
    import itlp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    itlp_bus_if.ctl bus,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [1:0] cmd_op_i,
    input wire logic [DATA_W-1:0] cmd_byte_i,
    input wire logic cmd_eoi_i,
    input wire logic ren_i,
    input wire logic ifc_i,
    output logic rsp_valid_o,
    output logic [DATA_W-1:0] rsp_data_o,
    output logic rsp_eoi_o,
    output logic srq_o
);
    localparam int NB = 5 + DATA_W;
    localparam int SW = $clog2(SETTLE_CYC + 1);
    logic [NB-1:0] s1_q, s2_q;
    logic dav_ls, nrfd_ls, ndac_ls, eoi_ls, srq_ls;
    logic [DATA_W-1:0] dio_ls;
    itlp_cs_t st_q, st_d;
    logic [SW-1:0] cnt_q;
    logic [DATA_W-1:0] byte_q, rsp_q;
    logic eoi_q, atn_q, ren_q, ifc_q, rsp_v_q, rsp_e_q;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s1_q <= '1;
            s2_q <= '1;
        end else begin
            s1_q <= {bus.dav_l, bus.nrfd_l, bus.ndac_l, bus.eoi_l, bus.srq_l,
                     bus.dio_l};
            s2_q <= s1_q;
        end
    end
    assign {dav_ls, nrfd_ls, ndac_ls, eoi_ls, srq_ls, dio_ls} = s2_q;
    wire dav = ~dav_ls;
    wire nrfd = ~nrfd_ls;
    wire ndac = ~ndac_ls;

    assign cmd_ready_o = (st_q == C_IDLE) & ~ifc_q;
    wire go = cmd_valid_i & cmd_ready_o;
    wire src = (st_q == C_SETTLE) | (st_q == C_WAIT) | (st_q == C_DAV)
               | (st_q == C_DONE);
    wire rx_take = (st_q == C_RX_RDY) & dav;
    always_comb begin
        st_d = st_q;
        case (st_q)
            C_IDLE: begin
                if (go && cmd_op_i == OP_RECV) st_d = C_RX_RDY;
                else if (go && cmd_op_i != OP_STBY) st_d = C_SETTLE;
            end
            C_SETTLE: if (cnt_q == SW'(SETTLE_CYC - 1)) st_d = C_WAIT;
            C_WAIT: if (!nrfd && ndac) st_d = C_DAV;
            C_DAV: if (!ndac) st_d = C_DONE;
            C_DONE: st_d = C_IDLE;
            C_RX_RDY: if (dav) st_d = C_RX_ACC;
            C_RX_ACC: if (!dav) st_d = C_IDLE;
            default: st_d = C_IDLE;
        endcase
        if (ifc_q) st_d = C_IDLE;
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_q <= C_IDLE;
            cnt_q <= '0;
            ren_q <= 1'b0;
            ifc_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= (st_q == C_SETTLE) ? cnt_q + 1'b1 : '0;
            ren_q <= ren_i;
            ifc_q <= ifc_i;
        end
    end
    // attention held from a command until data, receive or standby
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || ifc_q) begin
            atn_q <= 1'b0;
            byte_q <= '0;
            eoi_q <= 1'b0;
        end else if (go) begin
            atn_q <= cmd_op_i == OP_CMD;
            byte_q <= cmd_byte_i;
            eoi_q <= (cmd_op_i == OP_DATA) & cmd_eoi_i;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rsp_v_q <= 1'b0;
            rsp_q <= '0;
            rsp_e_q <= 1'b0;
        end else begin
            rsp_v_q <= rx_take;
            if (rx_take) rsp_q <= ~dio_ls;
            if (rx_take) rsp_e_q <= ~eoi_ls;
        end
    end
    assign bus.c_dio_oe = src ? byte_q : '0;
    assign bus.c_dio_o = '0;
    assign bus.c_dav_oe = st_q == C_DAV;
    assign bus.c_dav_o = 1'b0;
    assign bus.c_eoi_oe = src & eoi_q;
    assign bus.c_eoi_o = 1'b0;
    assign bus.c_nrfd_oe = st_q == C_RX_ACC;
    assign bus.c_nrfd_o = 1'b0;
    assign bus.c_ndac_oe = st_q == C_RX_RDY;
    assign bus.c_ndac_o = 1'b0;
    assign bus.c_atn_oe = atn_q;
    assign bus.c_atn_o = 1'b0;
    assign bus.c_ifc_oe = ifc_q;
    assign bus.c_ifc_o = 1'b0;
    assign bus.c_ren_oe = ren_q;
    assign bus.c_ren_o = 1'b0;
    assign rsp_valid_o = rsp_v_q;
    assign rsp_data_o = rsp_q;
    assign rsp_eoi_o = rsp_e_q;
    assign srq_o = ~srq_ls;
endmodule

// ---- hdl/itlp_dev.sv ----
// instrument end: talker, listener, service request and local/remote keys
module itlp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, rd_q;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = wr_q == rd_q;
    wire push = in_valid_i & ~full;
    wire pop = out_valid_o & out_ready_i;
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (push) mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
endmodule

module itlp_key #(
    parameter int HOLD = 16
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic key_i,
    output logic press_o,
    output logic long_o
);
    localparam int CW = $clog2(HOLD + 1);
    logic key_q, long_q;
    logic [CW-1:0] cnt_q;
    assign press_o = key_i & ~key_q;
    assign long_o = long_q;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            key_q <= 1'b0;
            cnt_q <= '0;
            long_q <= 1'b0;
        end else begin
            key_q <= key_i;
            if (!key_i) cnt_q <= '0;
            else if (cnt_q != CW'(HOLD)) cnt_q <= cnt_q + 1'b1;
            long_q <= key_i && (cnt_q == CW'(HOLD));
        end
    end
endmodule

module itlp_dev
    import itlp_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int NK = NKEYS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    itlp_bus_if.dev bus,
    output logic [DATA_W-1:0] rx_data_o,
    output logic rx_eoi_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic [DATA_W-1:0] tx_data_i,
    input wire logic tx_last_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic svc_req_i,
    input wire logic [STAT_W-1:0] status_i,
    input wire logic local_key_i,
    input wire logic remote_key_i,
    input wire logic [NK-1:0] panel_keys_i,
    output logic [NK-1:0] panel_keys_o,
    input wire logic delim_sw_i,
    input wire logic [ADDR_W-1:0] addr_sw_i,
    output logic remote_o,
    output logic listen_o,
    output logic talk_o,
    output logic show_curve_o,
    output logic show_addr_o,
    output logic [ADDR_W-1:0] bus_addr_o
);
    localparam int NB = 7 + DATA_W;
    localparam int NU = 3 + NK + ADDR_W;
    localparam int SW = $clog2(SETTLE_CYC + 1);
    logic [NB-1:0] bs1_q, bs2_q;
    logic [NU-1:0] us1_q, us2_q;
    logic ifc_ls, atn_ls, ren_ls, eoi_ls, dav_ls, nrfd_ls, ndac_ls;
    logic [DATA_W-1:0] dio_ls;
    logic loc_s, rem_s, delim_s;
    logic [NK-1:0] keys_s;
    logic [ADDR_W-1:0] addr_s;
    itlp_ah_t ah_q, ah_d;
    itlp_sh_t sh_q, sh_d;
    logic listen_q, talk_q, spoll_q, sp_sent_q, srq_q, remote_q, ren_q;
    logic [1:0] term_q;
    logic [SW-1:0] st_q;
    logic [DATA_W-1:0] tx_byte_q;
    logic tx_eoi_q;
    logic [ADDR_W-1:0] addr_q;
    logic [NK-1:0] panel_q;
    logic rx_in_ready, tx_out_valid, loc_press, rem_press;
    logic [DATA_W:0] tx_out;
    logic [DATA_W:0] rx_out;

    // two-stage synchronisers for every bus line, key and switch
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            bs1_q <= '1;
            bs2_q <= '1;
            us1_q <= '0;
            us2_q <= '0;
        end else begin
            bs1_q <= {bus.ifc_l, bus.atn_l, bus.ren_l, bus.eoi_l, bus.dav_l,
                      bus.nrfd_l, bus.ndac_l, bus.dio_l};
            bs2_q <= bs1_q;
            us1_q <= {local_key_i, remote_key_i, delim_sw_i, panel_keys_i,
                      addr_sw_i};
            us2_q <= us1_q;
        end
    end
    assign {ifc_ls, atn_ls, ren_ls, eoi_ls, dav_ls, nrfd_ls, ndac_ls,
            dio_ls} = bs2_q;
    assign {loc_s, rem_s, delim_s, keys_s, addr_s} = us2_q;

    // active-low lines turned to asserted-high terms
    wire ifc = ~ifc_ls;
    wire atn = ~atn_ls;
    wire ren = ~ren_ls;
    wire eoi = ~eoi_ls;
    wire dav = ~dav_ls;
    wire nrfd = ~nrfd_ls;
    wire ndac = ~ndac_ls;
    wire [DATA_W-1:0] bus_byte = ~dio_ls;
    wire [7:0] cmd = bus_byte & CMD_MASK;
    wire [7:0] my_addr = 8'(addr_s);
    wire is_la = (cmd & GROUP_MASK) == LA_BASE;
    wire is_ta = (cmd & GROUP_MASK) == TA_BASE;
    wire is_mla = cmd == (LA_BASE | my_addr);
    wire is_mta = cmd == (TA_BASE | my_addr);
    wire listen_eff = listen_q & ren;
    wire talk_act = talk_q & ren & ~atn & ~ifc;

    // acceptor: commands whenever attention, data only when addressed
    wire ah_active = ~ifc & (atn | listen_eff);
    wire ah_can = atn | rx_in_ready;
    wire take = (ah_q == AH_READY) & ah_active & dav & ah_can;
    wire cmd_take = take & atn & ~eoi;
    wire dat_take = take & ~atn;
    always_comb begin
        ah_d = ah_q;
        case (ah_q)
            AH_IDLE: if (ah_active) ah_d = AH_READY;
            AH_READY: begin
                if (!ah_active) ah_d = AH_IDLE;
                else if (take) ah_d = AH_ACC;
            end
            AH_ACC: if (!dav) ah_d = AH_READY;
            default: ah_d = AH_IDLE;
        endcase
        if (ifc) ah_d = AH_IDLE;
    end
    assign bus.d_nrfd_oe = ((ah_q == AH_READY) & ~ah_can)
                           | (ah_q == AH_ACC);
    assign bus.d_ndac_oe = ah_q == AH_READY;
    assign bus.d_nrfd_o = 1'b0;
    assign bus.d_ndac_o = 1'b0;

    // addressing and serial poll state
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || ifc || !ren) begin
            listen_q <= 1'b0;
            talk_q <= 1'b0;
            spoll_q <= 1'b0;
        end else if (cmd_take) begin
            if (is_mla) begin
                listen_q <= 1'b1;
                talk_q <= 1'b0;
            end else if (cmd == CMD_UNL) begin
                listen_q <= 1'b0;
            end else if (is_mta) begin
                talk_q <= 1'b1;
                listen_q <= 1'b0;
            end else if (is_ta) begin
                talk_q <= 1'b0;
            end else if (cmd == CMD_SPE) begin
                spoll_q <= 1'b1;
            end else if (cmd == CMD_SPD) begin
                spoll_q <= 1'b0;
            end
        end
    end

    // talker source: status byte in poll, else queue and delimiters
    wire have = spoll_q ? ~sp_sent_q
                        : ((term_q != TERM_NONE) | tx_out_valid);
    wire load = (sh_q == SH_IDLE) & talk_act & have;
    wire [7:0] term1 = delim_s ? CHR_LF : CHR_CR;
    wire [7:0] term2 = delim_s ? CHR_CR : CHR_LF;
    wire [7:0] status_byte = {1'b0, srq_q, status_i};
    wire [7:0] ld_byte = spoll_q ? status_byte
                       : (term_q == TERM_1) ? term1
                       : (term_q == TERM_2) ? term2 : tx_out[DATA_W-1:0];
    wire ld_eoi = ~spoll_q & (term_q == TERM_2);
    wire tx_pop = load & ~spoll_q & (term_q == TERM_NONE);
    wire accepted = (sh_q == SH_DAV) & ~ndac & talk_act;
    always_comb begin
        sh_d = sh_q;
        case (sh_q)
            SH_IDLE: if (load) sh_d = SH_SETTLE;
            SH_SETTLE: if (st_q == SW'(SETTLE_CYC - 1)) sh_d = SH_WAIT;
            SH_WAIT: if (!nrfd && ndac) sh_d = SH_DAV;
            SH_DAV: if (!ndac) sh_d = SH_DONE;
            SH_DONE: sh_d = SH_IDLE;
            default: sh_d = SH_IDLE;
        endcase
        if (!talk_act) sh_d = SH_IDLE;
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tx_byte_q <= '0;
            tx_eoi_q <= 1'b0;
            st_q <= '0;
        end else begin
            st_q <= (sh_q == SH_SETTLE) ? st_q + 1'b1 : '0;
            if (load) tx_byte_q <= ld_byte;
            if (load) tx_eoi_q <= ld_eoi;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || ifc) begin
            term_q <= TERM_NONE;
        end else if (load && !spoll_q) begin
            if (term_q == TERM_1) term_q <= TERM_2;
            else if (term_q == TERM_2) term_q <= TERM_NONE;
            else if (tx_out[DATA_W]) term_q <= TERM_1;
        end
    end
    // byte on the lines from settle on, valid only after it
    wire driving = sh_q != SH_IDLE;
    assign bus.d_dio_oe = driving ? tx_byte_q : '0;
    assign bus.d_dio_o = '0;
    assign bus.d_dav_oe = sh_q == SH_DAV;
    assign bus.d_dav_o = 1'b0;
    assign bus.d_eoi_oe = driving & tx_eoi_q;
    assign bus.d_eoi_o = 1'b0;

    // service request held until the status byte is taken, set wins
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            srq_q <= 1'b0;
            sp_sent_q <= 1'b0;
        end else begin
            if (svc_req_i) srq_q <= 1'b1;
            else if (accepted && spoll_q) srq_q <= 1'b0;
            if (!spoll_q) sp_sent_q <= 1'b0;
            else if (accepted) sp_sent_q <= 1'b1;
        end
    end
    assign bus.d_srq_oe = srq_q;
    assign bus.d_srq_o = 1'b0;

    // local and remote keys, panel lockout
    itlp_key #(.HOLD(HOLD_CYCLES)) u_loc (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .key_i(loc_s),
        .press_o(loc_press),
        .long_o(show_curve_o)
    );
    itlp_key #(.HOLD(HOLD_CYCLES)) u_rem (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .key_i(rem_s),
        .press_o(rem_press),
        .long_o(show_addr_o)
    );
    wire gtl_take = cmd_take & listen_eff & (cmd == CMD_GTL);
    wire ren_drop = ren_q & ~ren;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            remote_q <= 1'b0;
            ren_q <= 1'b0;
            addr_q <= '0;
            panel_q <= '0;
        end else begin
            ren_q <= ren;
            addr_q <= addr_s;
            panel_q <= remote_q ? '0 : keys_s;
            if (loc_press) remote_q <= 1'b0;
            else if (rem_press) remote_q <= 1'b1;
            else if (cmd_take && is_mla) remote_q <= 1'b1;
            else if (ren_drop || gtl_take) remote_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ah_q <= AH_IDLE;
            sh_q <= SH_IDLE;
        end else begin
            ah_q <= ah_d;
            sh_q <= sh_d;
        end
    end

    // byte queues between bus and user; full receive queue stalls ready
    itlp_fifo #(.W(DATA_W + 1), .DEPTH(DEPTH)) u_rx (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .in_data_i({eoi, bus_byte}),
        .in_valid_i(dat_take),
        .in_ready_o(rx_in_ready),
        .out_data_o(rx_out),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i)
    );
    itlp_fifo #(.W(DATA_W + 1), .DEPTH(DEPTH)) u_tx (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .in_data_i({tx_last_i, tx_data_i}),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .out_data_o(tx_out),
        .out_valid_o(tx_out_valid),
        .out_ready_i(tx_pop)
    );
    // no attention, clear or remote enable driver exists here
    assign rx_data_o = rx_out[DATA_W-1:0];
    assign rx_eoi_o = rx_out[DATA_W];
    assign remote_o = remote_q;
    assign listen_o = listen_q;
    assign talk_o = talk_q;
    assign bus_addr_o = addr_q;
    assign panel_keys_o = panel_q;
endmodule

// ---- hdl/itlp_pkg.sv ----
// constants, types and state codes shared by both ends of the bus port
package itlp_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int MS_PER_S = 1000;
    localparam int HOLD_MS = 1000;
    localparam int HOLD_CYC = CLK_HZ / MS_PER_S * HOLD_MS;
    localparam int SETTLE_CYC = 2;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int STAT_W = 6;
    localparam int FIFO_DEPTH = 4;
    localparam int NKEYS = 8;
    localparam logic [7:0] CMD_MASK = 8'h7f;
    localparam logic [7:0] GROUP_MASK = 8'h60;
    localparam logic [7:0] LA_BASE = 8'h20;
    localparam logic [7:0] TA_BASE = 8'h40;
    localparam logic [7:0] CMD_UNL = 8'h3f;
    localparam logic [7:0] CMD_SPE = 8'h18;
    localparam logic [7:0] CMD_SPD = 8'h19;
    localparam logic [7:0] CMD_GTL = 8'h01;
    localparam logic [7:0] CHR_CR = 8'h0d;
    localparam logic [7:0] CHR_LF = 8'h0a;
    localparam logic [1:0] TERM_NONE = 2'h0;
    localparam logic [1:0] TERM_1 = 2'h1;
    localparam logic [1:0] TERM_2 = 2'h2;
    typedef enum logic [2:0] {
        SH_IDLE = 3'b000,
        SH_SETTLE = 3'b001,
        SH_WAIT = 3'b010,
        SH_DAV = 3'b011,
        SH_DONE = 3'b100
    } itlp_sh_t;
    typedef enum logic [1:0] {
        AH_IDLE = 2'b00,
        AH_READY = 2'b01,
        AH_ACC = 2'b10
    } itlp_ah_t;
    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_SETTLE = 3'b001,
        C_WAIT = 3'b010,
        C_DAV = 3'b011,
        C_DONE = 3'b100,
        C_RX_RDY = 3'b101,
        C_RX_ACC = 3'b110
    } itlp_cs_t;
    typedef enum logic [1:0] {
        OP_CMD = 2'b00,
        OP_DATA = 2'b01,
        OP_RECV = 2'b10,
        OP_STBY = 2'b11
    } itlp_op_t;
endpackage

// ---- testbench/itlp_assertions.sv ----
// handshake checks on the resolved bus lines, management checks on the instrument's drivers
module itlp_assertions (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [7:0] dio_l,
    input wire logic dav_l,
    input wire logic nrfd_l,
    input wire logic ndac_l,
    input wire logic ifc_l,
    input wire logic atn_l,
    input wire logic ren_l,
    input wire logic d_dav_oe,
    input wire logic d_eoi_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    sequence dav_falls;
        $fell(dav_l);
    endsequence
    a_data_first: assert property (dav_falls |-> $stable(dio_l))
        else $error("data changed as valid asserted");
    a_ready_first: assert property (dav_falls |-> $past(nrfd_l))
        else $error("valid asserted while not ready");
    // an acceptor that leaves the handshake also lets go of accepted; only
    // a release paired with not-ready marks a captured byte
    a_accept_late: assert property ($rose(ndac_l) && !nrfd_l |-> !dav_l)
        else $error("accepted released without valid");
    a_valid_drop: assert property ($rose(dav_l) |-> $past(ndac_l))
        else $error("valid released before accepted");
    a_valid_ends: assert property (dav_falls |-> ##[1:60] dav_l)
        else $error("transfer did not complete");
    a_clear_idle: assert property (!ifc_l [*4] |-> !d_dav_oe && !d_eoi_oe)
        else $error("instrument drives bus during clear");
    a_atn_silent: assert property (!atn_l [*5] |-> !d_dav_oe && !d_eoi_oe)
        else $error("instrument talks under attention");
    a_ren_needed: assert property (ren_l [*5] |-> !d_dav_oe)
        else $error("instrument talks without remote enable");
endmodule

// ---- testbench/test_ieee488_talker_listener_port.sv ----
// end-to-end bench: controller end drives the instrument end over the bus
module test_ieee488_talker_listener_port import itlp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 0, srst_i = 1, rx_ready_i = 0, svc_req_i = 0;
    logic tx_last_i = 1, tx_valid_i = 0, local_key_i = 0, remote_key_i = 0;
    logic cmd_valid_i = 0, cmd_eoi_i = 0, ren_i = 1, ifc_i = 0;
    logic [7:0] tx_data_i = 8'h41, cmd_byte_i = 0, panel_keys_i = 8'hff;
    logic [7:0] rx_data_o, rsp_data_o, panel_keys_o;
    logic [1:0] cmd_op_i = 0;
    logic [4:0] bus_addr_o;
    logic [8:0] rsp;
    logic rx_eoi_o, rx_valid_o, tx_ready_o, remote_o, listen_o, talk_o;
    logic show_curve_o, show_addr_o, cmd_ready_o, rsp_valid_o, rsp_eoi_o;
    logic srq_o;
    int errors = 0, n_tests = 0;
    itlp_bus_if bus();
    itlp_dev #(.HOLD_CYCLES(20)) i_itlp_dev (.clk_sys_i, .srst_i, .bus(bus),
        .rx_data_o, .rx_eoi_o, .rx_valid_o, .rx_ready_i, .tx_data_i,
        .tx_last_i, .tx_valid_i, .tx_ready_o, .svc_req_i, .status_i(6'h15),
        .local_key_i, .remote_key_i, .panel_keys_i, .panel_keys_o,
        .delim_sw_i(1'b0), .addr_sw_i(5'h0c), .remote_o, .listen_o, .talk_o,
        .show_curve_o, .show_addr_o, .bus_addr_o);
    itlp_ctl i_itlp_ctl (.clk_sys_i, .srst_i, .bus(bus), .cmd_valid_i,
        .cmd_ready_o, .cmd_op_i, .cmd_byte_i, .cmd_eoi_i, .ren_i, .ifc_i,
        .rsp_valid_o, .rsp_data_o, .rsp_eoi_o, .srq_o);
    itlp_assertions i_itlp_assertions (.clk_sys_i, .srst_i,
        .dio_l(bus.dio_l), .dav_l(bus.dav_l), .nrfd_l(bus.nrfd_l),
        .ndac_l(bus.ndac_l), .ifc_l(bus.ifc_l), .atn_l(bus.atn_l),
        .ren_l(bus.ren_l), .d_dav_oe(bus.d_dav_oe), .d_eoi_oe(bus.d_eoi_oe));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic results;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(string n, logic [9:0] e, logic [9:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic op(logic [1:0] o, logic [7:0] b, logic e);
        {cmd_op_i, cmd_byte_i, cmd_eoi_i, cmd_valid_i} = {o, b, e, 1'b1};
        repeat (200) begin
            @(posedge clk_sys_i);
            if (cmd_ready_o === 1'b1) break;
        end
        @(negedge clk_sys_i);
        cmd_valid_i = 0;
        repeat (300) begin
            if (rsp_valid_o === 1'b1) rsp = {rsp_eoi_o, rsp_data_o};
            if (cmd_ready_o === 1'b1) break;
            @(negedge clk_sys_i);
        end
    endtask
    task automatic recv(logic [8:0] e);
        rsp = 'x;
        op(OP_RECV, 8'h00, 1'b0);
        chk("rsp", {1'b0, e}, {1'b0, rsp});
    endtask
    task automatic pop(logic [8:0] e);
        chk("rx", {1'b1, e}, {rx_valid_o, rx_eoi_o, rx_data_o});
        rx_ready_i = 1;
        @(negedge clk_sys_i);
        rx_ready_i = 0;
        @(negedge clk_sys_i);
    endtask
    task automatic key(logic r);
        {remote_key_i, local_key_i} = r ? 2'b10 : 2'b01;
        repeat (30) @(negedge clk_sys_i);
        chk("key", r ? 10'h6 : 10'h1, {remote_o, show_addr_o, show_curve_o});
        {remote_key_i, local_key_i} = 2'b00;
        repeat (3) @(negedge clk_sys_i);
    endtask
    initial begin
        repeat (10) @(negedge clk_sys_i);
        srst_i = 0;
        repeat (3) @(negedge clk_sys_i);
        chk("addr", 10'h0c, bus_addr_o);
        op(OP_CMD, LA_BASE | 8'h0c, 1'b0);
        op(OP_STBY, 8'h00, 1'b0);
        chk("listen", 10'h3, {remote_o, listen_o});
        op(OP_DATA, 8'ha5, 1'b0);
        op(OP_DATA, 8'h3c, 1'b1);
        chk("keys", 10'h0, panel_keys_o);
        pop(9'h0a5);
        pop(9'h13c);
        op(OP_CMD, CMD_UNL, 1'b0);
        op(OP_CMD, TA_BASE | 8'h0c, 1'b0);
        op(OP_STBY, 8'h00, 1'b0);
        chk("talk", 10'h1, {listen_o, talk_o});
        chk("tx_rdy", 10'h1, tx_ready_o);
        tx_valid_i = 1;
        @(negedge clk_sys_i);
        tx_valid_i = 0;
        recv(9'h041);
        recv({1'b0, CHR_CR});
        recv({1'b1, CHR_LF});
        svc_req_i = 1;
        @(negedge clk_sys_i);
        svc_req_i = 0;
        repeat (5) @(negedge clk_sys_i);
        chk("srq", 10'h1, srq_o);
        op(OP_CMD, CMD_SPE, 1'b0);
        op(OP_STBY, 8'h00, 1'b0);
        recv(9'h055);
        op(OP_CMD, CMD_SPD, 1'b0);
        repeat (5) @(negedge clk_sys_i);
        chk("srq", 10'h0, srq_o);
        key(1'b0);
        chk("keys", 10'hff, panel_keys_o);
        key(1'b1);
        ifc_i = 1;
        repeat (6) @(negedge clk_sys_i);
        ifc_i = 0;
        repeat (4) @(negedge clk_sys_i);
        chk("ifc", 10'h0, {listen_o, talk_o});
        ren_i = 0;
        repeat (6) @(negedge clk_sys_i);
        chk("ren", 10'h0, remote_o);
        results;
    end
    initial begin
        #200000;
        errors++;
        results;
    end
endmodule
